// ===== design/cell_phy_defines.svh
// Constants for the receive host port and transmit self-test controls.
// Assumes a single 125 MHz ref_clk that also times both port sides.
`ifndef CELL_PHY_DEFINES_SVH
`define CELL_PHY_DEFINES_SVH

// ----------------------------------------------------------------
// Transmit queue reset
// ----------------------------------------------------------------
`define QRST_HOLD       4'h8
`define QRST_HOLD_LAST  4'h7

// ----------------------------------------------------------------
// Self-test pattern (9-bit LFSR, 511 states)
// ----------------------------------------------------------------
`define BIST_SEED       9'h1ff
`define BIST_LAST_POS   9'h1fe
`define BIST_TAP_HI     8
`define BIST_TAP_LO     4

// ----------------------------------------------------------------
// Receive modes and reset values
// ----------------------------------------------------------------
`define RX_MODE_SPECIAL 2'h3
`define CLAV_IDLE       1'b1
`define DECODE_RESET    3'h0

`endif

// ===== design/cell_phy_pkg.sv
// Types shared by the receive host port design files.
// Assumes nothing beyond the defines header.
package cell_phy_pkg;

  // Transmitter source select
  typedef enum logic [0:0] {
    TX_NORMAL    = 1'b0,
    TX_SELF_TEST = 1'b1
  } tx_mode_e;

  // One received character with its indicators
  typedef struct packed {
    logic [7:0] data;
    logic       violation;
    logic       cell_start;
    logic       special;
  } rx_char_s;

endpackage

// ===== design/decode_table_if.sv
// Carrier between the port logic and its special-character table.
// Assumes both ends share ref_clk.
interface decode_table_if;
  logic [2:0] rd_addr;   // Special code to look up
  logic [2:0] rd_data;   // {violation, cell_start, special}, registered
  logic       wr_en;     // Table load strobe
  logic [2:0] wr_addr;   // Entry to load
  logic [2:0] wr_data;   // Flag triple to load

  modport store  (input rd_addr, input wr_en, input wr_addr,
                  input wr_data, output rd_data);
  modport client (output rd_addr, output wr_en, output wr_addr,
                  output wr_data, input rd_data);
endinterface

// ===== design/special_decode_table.sv
// Eight-entry table mapping special codes to flag triples.
// Assumes loads and lookups share ref_clk; read data is registered.
`include "cell_phy_defines.svh"
module special_decode_table
(
  input  wire logic    ref_clk,   // Port clock
  input  wire logic    rst_n,     // Async reset, active low
  decode_table_if.store tbl       // Lookup and load port
);

  logic [2:0] entry [8];

  // ----------------------------------------------------------------
  // Storage and registered lookup
  // ----------------------------------------------------------------
  // Entries clear at reset so an unloaded table reads as plain data
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 8; i++)
        entry[i] <= `DECODE_RESET;
      tbl.rd_data <= `DECODE_RESET;
    end
    else
    begin
      if (tbl.wr_en)
        entry[tbl.wr_addr] <= tbl.wr_data;
      tbl.rd_data <= entry[tbl.rd_addr];
    end
  end

endmodule // special_decode_table

// ===== design/bist_pattern_gen.sv
// Self-test pattern source: 511-character LFSR sequence.
// Assumes run is already synchronised to ref_clk.
`include "cell_phy_defines.svh"
module bist_pattern_gen
(
  input  wire logic       ref_clk,      // Port clock
  input  wire logic       rst_n,        // Async reset, active low
  input  wire logic       run,          // Sequence advances while high
  output logic [7:0]      pattern_char, // Current test character
  output logic            seq_end       // One cycle per finished sequence
);

  logic [8:0] lfsr;
  logic [8:0] pos;
  logic [8:0] next_lfsr;

  // ----------------------------------------------------------------
  // Shift register feedback
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 1; g < 9; g++)
    begin : g_shift
      assign next_lfsr[g] = lfsr[g-1];
    end
  endgenerate
  assign next_lfsr[0] = lfsr[`BIST_TAP_HI] ^ lfsr[`BIST_TAP_LO];

  // Restarting from the seed gives the far end a known first char
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lfsr    <= `BIST_SEED;
      pos     <= '0;
      seq_end <= 1'b0;
    end
    else if (!run)
    begin
      lfsr    <= `BIST_SEED;
      pos     <= '0;
      seq_end <= 1'b0;
    end
    else
    begin
      lfsr    <= next_lfsr;
      seq_end <= (pos == `BIST_LAST_POS);
      pos     <= (pos == `BIST_LAST_POS) ? 9'h000 : pos + 9'h001;
    end
  end

  assign pattern_char = lfsr[7:0];

endmodule // bist_pattern_gen

// ===== design/cell_phy_receive_host_port.sv
// Receive host port, queue reset request and transmit self-test.
// Assumes ref_clk stands for both the receive and transmit side
// clocks; port inputs are synchronous, self-test pins are not.
`include "cell_phy_defines.svh"
module cell_phy_receive_host_port
(
  input  wire logic       ref_clk,                        // 125 MHz
  input  wire logic       rst_n,                          // Async, low
  input  wire logic       transmit_queue_reset_request_n, // Low = reset
  input  wire logic       transmit_self_test_enable_n,    // Async pin
  input  wire logic       receive_self_test_enable_n,     // Async pin
  input  wire logic       cascade_timing_select,          // Static pin
  input  wire logic       receive_port_enable,            // Polarity var
  input  wire logic [2:0] receive_port_select,            // Host address
  input  wire logic [2:0] port_identity_strap,            // Our address
  input  wire logic [1:0] rx_mode,                        // Receive mode
  input  wire logic       rx_char_valid,                  // Char present
  input  wire logic [7:0] rx_char_byte,                   // Decoded byte
  input  wire logic       rx_char_special,                // Special char
  input  wire logic       rx_char_cell_start,             // Cell start
  input  wire logic       rx_char_error,                  // Errored char
  input  wire logic [2:0] rx_special_code,                // Special index
  input  wire logic       rx_self_test_mismatch,          // Checker miss
  input  wire logic       rx_cell_ready,                  // Full cell in
  input  wire logic       decode_wr_en,                   // Table load
  input  wire logic [2:0] decode_wr_addr,                 // Table entry
  input  wire logic [2:0] decode_wr_data,                 // Flag triple
  input  wire logic       tx_queue_read_request,          // Wants a byte
  input  wire logic       tx_queue_not_empty,             // Queue holds
  input  wire logic [7:0] tx_queue_byte,                  // Queue head
  output logic [7:0]      receive_byte_output,            // Byte out
  output logic            receive_violation_flag,         // Violation
  output logic            receive_cell_start_flag,        // Cell start
  output logic            receive_special_or_data_flag,   // High special
  output logic            receive_bus_oe,                 // Drive enable
  output logic            receive_cell_available_flag,    // Low = cell
  output logic            receive_cell_available_oe,      // Drive enable
  output logic            transmit_queue_empty_flag,      // Polarity var
  output logic            tx_queue_read,                  // Pop queue
  output logic            tx_queue_reset,                 // Reset pulse
  output logic [7:0]      tx_char_out,                    // To encoder
  output logic            tx_char_is_pattern              // Test char
);

  // ----------------------------------------------------------------
  // Shared decode
  // ----------------------------------------------------------------
  // Level that a flag shows when asserted, per timing convention
  function automatic logic flag_level(input logic asserted,
                                      input logic cascade);
    flag_level = asserted ? cascade : ~cascade;
  endfunction

  // ----------------------------------------------------------------
  // Synchronisers and strap capture
  // ----------------------------------------------------------------
  logic       tx_test_s1, tx_test_s2;
  logic       rx_test_s1, rx_test_s2;
  logic       casc_s1, cascade_q;
  logic [2:0] strap_q;
  logic       strap_taken;

  // Only the second stage feeds logic; first stage is metastable-prone
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_test_s1 <= 1'b1;
      tx_test_s2 <= 1'b1;
      rx_test_s1 <= 1'b1;
      rx_test_s2 <= 1'b1;
      casc_s1    <= 1'b0;
      cascade_q  <= 1'b0;
    end
    else
    begin
      tx_test_s1 <= transmit_self_test_enable_n;
      tx_test_s2 <= tx_test_s1;
      rx_test_s1 <= receive_self_test_enable_n;
      rx_test_s2 <= rx_test_s1;
      casc_s1    <= cascade_timing_select;
      cascade_q  <= casc_s1;
    end
  end

  // Strap is caught on the first edge after release, then frozen
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_q     <= 3'h0;
      strap_taken <= 1'b0;
    end
    else if (!strap_taken)
    begin
      strap_q     <= port_identity_strap;
      strap_taken <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Port selection
  // ----------------------------------------------------------------
  logic port_match;
  logic enable_active;
  logic rx_sel;

  // Enable is active when it equals the cascade select level
  assign enable_active = (receive_port_enable == cascade_q);
  assign port_match    = strap_taken &&
                         (receive_port_select == strap_q);
  assign rx_sel        = port_match && enable_active;

  // ----------------------------------------------------------------
  // Receive pipeline and table lookup
  // ----------------------------------------------------------------
  decode_table_if tbl_bus ();
  cell_phy_pkg::rx_char_s p_char;
  logic       p_valid;
  logic [1:0] p_mode;
  logic       p_mismatch;
  logic       p_test;

  assign tbl_bus.rd_addr = rx_special_code;
  assign tbl_bus.wr_en   = decode_wr_en;
  assign tbl_bus.wr_addr = decode_wr_addr;
  assign tbl_bus.wr_data = decode_wr_data;

  special_decode_table u_table
  (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .tbl     (tbl_bus.store)
  );

  // One stage so source fields line up with the registered lookup
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      p_char     <= '0;
      p_valid    <= 1'b0;
      p_mode     <= 2'h0;
      p_mismatch <= 1'b0;
      p_test     <= 1'b0;
    end
    else
    begin
      p_char     <= {rx_char_byte, rx_char_error, rx_char_cell_start,
                     rx_char_special};
      p_valid    <= rx_char_valid;
      p_mode     <= rx_mode;
      p_mismatch <= rx_self_test_mismatch;
      p_test     <= !rx_test_s2;
    end
  end

  // ----------------------------------------------------------------
  // Indicator decode
  // ----------------------------------------------------------------
  logic mode_special;
  logic use_table;
  logic dec_violation;
  logic dec_cell_start;
  logic dec_special;

  assign mode_special   = (p_mode == `RX_MODE_SPECIAL);
  assign use_table      = mode_special && p_char.special;
  // Outside mode 11 the flag is idle unless the checker runs
  assign dec_violation  = use_table    ? tbl_bus.rd_data[2] :
                          mode_special ? p_char.violation :
                          (p_test && p_mismatch);
  assign dec_cell_start = use_table ? tbl_bus.rd_data[1] :
                          p_char.cell_start;
  assign dec_special    = use_table ? tbl_bus.rd_data[0] :
                          p_char.special;

  // ----------------------------------------------------------------
  // Receive outputs (all timed by the receive side clock)
  // ----------------------------------------------------------------
  // Bytes not taken while deselected are dropped, not queued
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      receive_byte_output          <= 8'h00;
      receive_violation_flag       <= 1'b0;
      receive_cell_start_flag      <= 1'b0;
      receive_special_or_data_flag <= 1'b0;
      receive_bus_oe               <= 1'b0;
      receive_cell_available_flag  <= `CLAV_IDLE;
      receive_cell_available_oe    <= 1'b0;
    end
    else
    begin
      receive_bus_oe            <= rx_sel;
      receive_cell_available_oe <= port_match;
      if (rx_sel)
        receive_cell_available_flag <= !rx_cell_ready;
      if (rx_sel && p_valid)
      begin
        receive_byte_output          <= p_char.data;
        receive_violation_flag       <= dec_violation;
        receive_cell_start_flag      <= dec_cell_start;
        receive_special_or_data_flag <= dec_special;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit queue reset request
  // ----------------------------------------------------------------
  logic [3:0] qrst_cnt;

  // Fires once per hold; a glitch shorter than eight samples is ignored
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      qrst_cnt       <= 4'h0;
      tx_queue_reset <= 1'b0;
    end
    else
    begin
      tx_queue_reset <= !transmit_queue_reset_request_n &&
                        (qrst_cnt == `QRST_HOLD_LAST);
      if (transmit_queue_reset_request_n)
        qrst_cnt <= 4'h0;
      else if (qrst_cnt != `QRST_HOLD)
        qrst_cnt <= qrst_cnt + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Transmit self-test control
  // ----------------------------------------------------------------
  cell_phy_pkg::tx_mode_e tx_mode;
  cell_phy_pkg::tx_mode_e next_tx_mode;
  logic       bist_active;
  logic [7:0] pattern_char;
  logic       bist_end;
  logic       empty_asserted;

  always_comb
  begin
    case (tx_mode)
      cell_phy_pkg::TX_NORMAL:
        next_tx_mode = tx_test_s2 ? cell_phy_pkg::TX_NORMAL
                                  : cell_phy_pkg::TX_SELF_TEST;
      cell_phy_pkg::TX_SELF_TEST:
        next_tx_mode = tx_test_s2 ? cell_phy_pkg::TX_NORMAL
                                  : cell_phy_pkg::TX_SELF_TEST;
      default:
        next_tx_mode = cell_phy_pkg::TX_NORMAL;
    endcase
  end

  assign bist_active    = (tx_mode == cell_phy_pkg::TX_SELF_TEST);
  assign empty_asserted = (transmit_queue_empty_flag == cascade_q);

  bist_pattern_gen u_bist
  (
    .ref_clk      (ref_clk),
    .rst_n        (rst_n),
    .run          (bist_active),
    .pattern_char (pattern_char),
    .seq_end      (bist_end)
  );

  // Queue is frozen during test so its contents survive the test
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_mode                   <= cell_phy_pkg::TX_NORMAL;
      tx_queue_read             <= 1'b0;
      tx_char_out               <= 8'h00;
      tx_char_is_pattern        <= 1'b0;
      transmit_queue_empty_flag <= 1'b0;
    end
    else
    begin
      tx_mode            <= next_tx_mode;
      tx_queue_read      <= !bist_active && tx_queue_read_request &&
                            tx_queue_not_empty;
      tx_char_out        <= bist_active ? pattern_char
                                        : tx_queue_byte;
      tx_char_is_pattern <= bist_active;
      transmit_queue_empty_flag <=
        flag_level(bist_active ? bist_end : !tx_queue_not_empty,
                   cascade_q);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [8:0] gap;
  logic       gap_seen;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gap      <= 9'h000;
      gap_seen <= 1'b0;
    end
    else
    begin
      gap      <= (!bist_active || bist_end) ? 9'h000 : gap + 9'h001;
      gap_seen <= bist_active && (gap_seen || bist_end);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_req_held;
    transmit_queue_reset_request_n ##1 (!transmit_queue_reset_request_n)[*8];
  endsequence

  sequence s_test_end;
    bist_active && bist_end ##1 bist_active;
  endsequence

  AST_QRST_FIRES: assert property (s_req_held |=> tx_queue_reset)
    else $error("queue reset not started after eight low samples");
  AST_QRST_EARLY: assert property (tx_queue_reset |->
    !$past(transmit_queue_reset_request_n, 1) &&
    !$past(transmit_queue_reset_request_n, 8))
    else $error("queue reset started too early");
  AST_BIST_PERIOD: assert property (bist_end && gap_seen |->
    gap == `BIST_LAST_POS)
    else $error("self-test sequence length wrong");
  AST_TEST_RELEASE: assert property (
    $rose(transmit_self_test_enable_n) |-> ##[1:3] !bist_active)
    else $error("self-test did not end after release");
  AST_NO_READ: assert property (bist_active |=> !tx_queue_read)
    else $error("queue read during self-test");
  AST_RX_HOLD: assert property (
    !rx_sel |=> $stable(receive_byte_output))
    else $error("receive byte changed while deselected");
  AST_RX_UPDATE: assert property (rx_sel && p_valid |=>
    receive_byte_output == $past(p_char.data))
    else $error("receive byte not updated while selected");
  AST_VIOL_IDLE: assert property (
    rx_sel && p_valid && !mode_special && !p_test |=>
    !receive_violation_flag)
    else $error("violation flag set outside mode 11");
  AST_EN_POLARITY: assert property (
    (receive_port_enable != cascade_q) |=> !receive_bus_oe)
    else $error("bus driven with inactive enable");
  AST_ADDR_MATCH: assert property (
    (receive_port_select != strap_q) |=>
    !receive_bus_oe && !receive_cell_available_oe)
    else $error("bus driven with wrong port select");
  AST_EMPTY_PULSE: assert property (s_test_end |->
    empty_asserted ##1 !empty_asserted)
    else $error("empty flag not a single-cycle test pulse");
  AST_CLAV_FLOAT: assert property (
    port_match && !$past(port_match) |=> receive_cell_available_oe)
    else $error("cell-available not driven after match");

endmodule // cell_phy_receive_host_port

// ===== testbench/atm_layer_host.sv
// Host-side model of the cell-layer controller facing the receive port.
// Assumes ref_clk is shared and the polarity pin is steady while used.
module atm_layer_host
(
  input  wire logic  ref_clk,                       // Port clock
  input  wire logic  cascade_timing_select,         // Polarity pin
  output logic       receive_port_enable,           // To device
  output logic [2:0] receive_port_select,           // To device
  output logic       transmit_queue_reset_request_n // To device
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle: nobody addressed, enable inactive, no reset request
  initial
  begin
    receive_port_enable = 1'b1;
    receive_port_select = 3'h0;
    transmit_queue_reset_request_n = 1'b1;
  end

  // Address a port; the enable level depends on the timing style
  task automatic address(input logic [2:0] a, input logic on);
    @(posedge ref_clk);
    receive_port_select <= a;
    receive_port_enable <= on ? cascade_timing_select
                              : ~cascade_timing_select;
  endtask

  // Hold the request low for exactly k sampling edges
  task automatic queue_reset(input int k);
    @(posedge ref_clk);
    transmit_queue_reset_request_n <= 1'b0;
    repeat (k) @(posedge ref_clk);
    transmit_queue_reset_request_n <= 1'b1;
  endtask
endmodule // atm_layer_host

// ===== testbench/tb.sv
// Self-checking bench for the receive host port and transmit controls.
// Assumes the design files and atm_layer_host are compiled first.
module tb;
  timeunit 1ns;
  timeprecision 1ps;

`define CHECK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

  logic       ref_clk, rst_n, transmit_queue_reset_request_n;
  logic       transmit_self_test_enable_n, receive_self_test_enable_n;
  logic       cascade_timing_select, receive_port_enable, rx_char_valid;
  logic [2:0] receive_port_select, port_identity_strap, rx_special_code;
  logic [1:0] rx_mode, n;
  logic       rx_char_special, rx_char_cell_start, rx_char_error;
  logic       rx_self_test_mismatch, rx_cell_ready, decode_wr_en;
  logic [7:0] rx_char_byte, tx_queue_byte, receive_byte_output, tx_char_out;
  logic       tx_queue_read_request, tx_queue_not_empty, tx_queue_read;
  logic [2:0] decode_wr_addr, decode_wr_data;
  logic       receive_violation_flag, receive_cell_start_flag;
  logic       receive_special_or_data_flag, receive_bus_oe;
  logic       receive_cell_available_flag, receive_cell_available_oe;
  logic       transmit_queue_empty_flag, tx_queue_reset, tx_char_is_pattern;
  logic [10:0] at [2];
  logic [7:0]  ch [2];
  int          errors, cmp_count, resets_seen;

  cell_phy_receive_host_port u_cell_phy_receive_host_port (.*);

  atm_layer_host u_atm_layer_host (
    .ref_clk                        (ref_clk),
    .cascade_timing_select          (cascade_timing_select),
    .receive_port_enable            (receive_port_enable),
    .receive_port_select            (receive_port_select),
    .transmit_queue_reset_request_n (transmit_queue_reset_request_n)
  );

  // 125 MHz clock and time-zero values of every bench-driven input
  always #4 ref_clk = ~ref_clk;
  initial
  begin
    {ref_clk, rst_n, cascade_timing_select, rx_mode} = 5'h00;
    {transmit_self_test_enable_n, receive_self_test_enable_n} = 2'h3;
    {rx_char_valid, rx_char_special, rx_char_cell_start} = 3'h0;
    {rx_char_error, rx_self_test_mismatch, rx_cell_ready} = 3'h0;
    {decode_wr_en, decode_wr_addr, decode_wr_data, rx_special_code} = 10'h0;
    {tx_queue_read_request, tx_queue_not_empty} = 2'h0;
    {rx_char_byte, tx_queue_byte} = 16'h005a;
    port_identity_strap = 3'h5;
  end

  // Counts high cycles of the reset pulse, so a long pulse shows too
  always @(posedge ref_clk)
    if (tx_queue_reset === 1'b1)
      resets_seen++;

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  // Two-cycle reset, then wait out strap capture and synchronisers
  task automatic do_reset();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    cyc(4);
  endtask

  // One character; f is {special, cell start, error, mismatch}
  task automatic send_char(input logic [7:0] b, input logic [3:0] f,
                           input logic [2:0] code);
    @(posedge ref_clk);
    rx_char_valid <= 1'b1;
    rx_char_byte <= b;
    {rx_char_special, rx_char_cell_start, rx_char_error,
     rx_self_test_mismatch} <= f;
    rx_special_code <= code;
    @(posedge ref_clk);
    rx_char_valid <= 1'b0;
    cyc(4);
  endtask

  // Byte and the {violation, cell start, special} triple
  task automatic check_rx(input logic [7:0] b, input logic [2:0] t);
    `CHECK(receive_byte_output, b)
    `CHECK({receive_violation_flag, receive_cell_start_flag,
            receive_special_or_data_flag}, t)
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog: the tests need about 1150 cycles, allow 20000 cycles
  initial
  begin
    #(20000 * 8);
    errors++;
    summarize();
  end

  // Main test sequence
  initial
  begin
    int i;
    do_reset();
    u_atm_layer_host.address(3'h5, 1'b1);
    rx_cell_ready <= 1'b1;
    cyc(3);
    `CHECK({receive_cell_available_oe, receive_cell_available_flag},
           2'h2)
    send_char(8'ha5, 4'h6, 3'h0);
    check_rx(8'ha5, 3'h2);
    // The checker enable passes two sync stages before chars see it
    @(posedge ref_clk);
    receive_self_test_enable_n <= 1'b0;
    cyc(3);
    send_char(8'h3c, 4'h9, 3'h0);
    check_rx(8'h3c, 3'h5);
    @(posedge ref_clk);
    receive_self_test_enable_n <= 1'b1;
    rx_mode <= 2'h3;
    send_char(8'h11, 4'h2, 3'h0);
    check_rx(8'h11, 3'h4);
    for (i = 0; i < 2; i++)
    begin
      @(posedge ref_clk);
      {decode_wr_en, decode_wr_addr} <= {1'b1, 3'(5 - 3 * i)};
      decode_wr_data <= i ? 3'h4 : 3'h3;
      @(posedge ref_clk);
      decode_wr_en <= 1'b0;
      send_char(8'(8'h7e + i), 4'h8, 3'(5 - 3 * i));
      check_rx(8'(8'h7e + i), i ? 3'h4 : 3'h3);
    end
    u_atm_layer_host.address(3'h5, 1'b0);
    send_char(8'h99, 4'h0, 3'h0);
    `CHECK(receive_byte_output, 8'h7f)
    u_atm_layer_host.address(3'h2, 1'b1);
    send_char(8'h55, 4'h0, 3'h0);
    `CHECK(receive_byte_output, 8'h7f)
    `CHECK({receive_bus_oe, receive_cell_available_oe}, 2'h0)
    u_atm_layer_host.queue_reset(7);
    cyc(3);
    `CHECK(resets_seen, 0)
    u_atm_layer_host.queue_reset(12);
    cyc(3);
    `CHECK(resets_seen, 1)
    @(posedge ref_clk);
    {tx_queue_read_request, tx_queue_not_empty} <= 2'h2;
    cyc(3);
    `CHECK(transmit_queue_empty_flag, 1'b0)
    // Reads must run before the test so their stop is seen
    @(posedge ref_clk);
    tx_queue_not_empty <= 1'b1;
    cyc(3);
    `CHECK({transmit_queue_empty_flag, tx_queue_read}, 2'h3)
    @(posedge ref_clk);
    transmit_self_test_enable_n <= 1'b0;
    cyc(6);
    `CHECK({tx_queue_read, tx_char_is_pattern}, 2'h1)
    n = 2'h0;
    for (i = 0; i < 1200 && n < 2'h2; i++)
    begin
      cyc(1);
      if (transmit_queue_empty_flag === 1'b0)
      begin
        at[n[0]] = 11'(i);
        ch[n[0]] = tx_char_out;
        n++;
      end
    end
    `CHECK(n, 2'h2)
    `CHECK(11'(at[1] - at[0]), 11'h1ff)
    `CHECK(ch[1], ch[0])
    @(posedge ref_clk);
    transmit_self_test_enable_n <= 1'b1;
    cyc(6);
    `CHECK({tx_queue_read, tx_char_is_pattern}, 2'h2)
    `CHECK(tx_char_out, 8'h5a)
    @(posedge ref_clk);
    cascade_timing_select <= 1'b1;
    do_reset();
    u_atm_layer_host.address(3'h5, 1'b1);
    send_char(8'hc3, 4'h0, 3'h0);
    `CHECK(receive_byte_output, 8'hc3)
    @(posedge ref_clk);
    {tx_queue_not_empty, rx_cell_ready} <= 2'h0;
    cyc(3);
    `CHECK(transmit_queue_empty_flag, 1'b1)
    `CHECK({receive_cell_available_oe, receive_cell_available_flag},
           2'h3)
    summarize();
  end
endmodule // tb
